/* hw/pam_pkg.sv */
// Notes on behaviour
// - ten dedicated-input cells and ten bidirectional-pin input cells feed the array
// - each input cell passes its pin directly, latches it, or registers it
// - input-side clock gates latch-mode cells and clocks register-mode cells
// - dedicated-input and pin-input cell groups are configured independently
// - input-side clock and state register clock are separate and independent
// - eight hidden state cells feed back into the array only
// - ten pin-driving cells drive pins and feed back into the array
// - each state cell is combinational, sum-term clocked, or clock-enabled register
// - each pin-driving cell has its own output-enable term controlling direction
// - each pin-driving cell has a bit choosing true or inverted pin output
// - hidden cells give true and complement feedback instead of a polarity bit
// - each enable sum term passes through a programmable inversion bit
// - enable-register mode loads on state clock only while enable is asserted
// - sum-term-clock mode loads on the rising edge of its enable term unless the reset term is asserted
// - one active-high reset term clears all state cell registers at once
// - reset registers read zero, so registered pins show one while their output inversion bit is clear
// - each pin-driving cell feeds its own value back ahead of the driver
// - each pin also feeds back through its pin input cell, usable as input
// - enable-register mode lets set-reset, J-K and toggle be built from terms
// - hidden cells carry three configuration bits and no output polarity bit
package pam_pkg;
    localparam int unsigned NUM_IN     = 10;
    localparam int unsigned NUM_PIN    = 10;
    localparam int unsigned NUM_HIDDEN = 8;
    localparam int unsigned NUM_CELL   = NUM_PIN + NUM_HIDDEN;

    localparam logic [4:0] ADDR_DED_CFG   = 5'h00;
    localparam logic [4:0] ADDR_PIN_CFG   = 5'h04;
    localparam logic [4:0] ADDR_CLK_SEL   = 5'h08;
    localparam logic [4:0] ADDR_SYNC_SEL  = 5'h0c;
    localparam logic [4:0] ADDR_EN_POL    = 5'h10;
    localparam logic [4:0] ADDR_OUT_INV   = 5'h14;
    localparam logic [4:0] ADDR_CELL_STAT = 5'h18;
    localparam logic [4:0] ADDR_IN_STAT   = 5'h1c;

    localparam int unsigned IN_LATCH_LSB = 16;
    localparam int unsigned IN_STAT_PIN_LSB = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [NUM_CELL-1:0] CELL_CFG_RST = 18'h00000;
    localparam logic [NUM_PIN-1:0]  OUT_INV_RST  = 10'h000;
    localparam logic [NUM_IN-1:0]   IN_CFG_RST   = 10'h000;

    typedef struct packed {
        logic [NUM_IN-1:0] syncSel;
        logic [NUM_IN-1:0] latchSel;
    } pam_in_cfg_s;

    typedef struct packed {
        logic [NUM_CELL-1:0] clkSrcSel;
        logic [NUM_CELL-1:0] syncSel;
        logic [NUM_CELL-1:0] enPol;
    } pam_cell_cfg_s;

    typedef enum logic [1:0] {IN_ASYNC, IN_LATCH, IN_REG} pam_in_mode_e;
    typedef enum logic [1:0] {CELL_COMB, CELL_TERM_CLK, CELL_EN_REG} pam_cell_mode_e;
endpackage

/* hw/pam_top.sv */
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module pam_top
    import pam_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic [4:0]          s_axil_awaddr,
    input  wire logic                s_axil_awvalid,
    output logic                     s_axil_awready,
    input  wire logic [31:0]         s_axil_wdata,
    input  wire logic [3:0]          s_axil_wstrb,
    input  wire logic                s_axil_wvalid,
    output logic                     s_axil_wready,
    output logic [1:0]               s_axil_bresp,
    output logic                     s_axil_bvalid,
    input  wire logic                s_axil_bready,
    input  wire logic [4:0]          s_axil_araddr,
    input  wire logic                s_axil_arvalid,
    output logic                     s_axil_arready,
    output logic [31:0]              s_axil_rdata,
    output logic [1:0]               s_axil_rresp,
    output logic                     s_axil_rvalid,
    input  wire logic                s_axil_rready,
    input  wire logic                inputSideClock,
    input  wire logic                stateRegisterClock,
    input  wire logic [NUM_IN-1:0]   dedicatedInPin,
    input  wire logic [NUM_PIN-1:0]  bidirPinIn,
    input  wire logic [NUM_CELL-1:0] dataSumTerm,
    input  wire logic [NUM_CELL-1:0] enableSumTerm,
    input  wire logic [NUM_PIN-1:0]  outputEnableTerm,
    input  wire logic                resetTerm,
    output logic [NUM_IN-1:0]        dedicatedInToArray,
    output logic [NUM_PIN-1:0]       pinInToArray,
    output logic [NUM_CELL-1:0]      cellFeedback,
    output logic [NUM_CELL-1:0]      cellFeedbackN,
    output logic [NUM_PIN-1:0]       bidirPinOut,
    output logic [NUM_PIN-1:0]       bidirPinOe_n
);
    pam_in_cfg_s         dedCfg;
    pam_in_cfg_s         pinCfg;
    pam_cell_cfg_s       cellCfg;
    logic [NUM_PIN-1:0]  outInv;
    logic [NUM_IN-1:0]   dedMeta;
    logic [NUM_IN-1:0]   dedSync;
    logic [NUM_PIN-1:0]  pinMeta;
    logic [NUM_PIN-1:0]  pinSync;
    logic [1:0]          inClkMeta;
    logic [1:0]          inClkSync;
    logic                inClkPrev;
    logic                stClkPrev;
    logic [NUM_CELL-1:0] enPrev;
    logic [NUM_CELL-1:0] cellEn;
    logic                inClkRise;
    logic                stClkRise;
    logic [NUM_IN-1:0]   next_dedIn;
    logic [NUM_PIN-1:0]  next_pinIn;
    logic [NUM_CELL-1:0] next_cell;
    logic [4:0]          awAddr;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                gotAw;
    logic                gotW;
    logic                writeCommit;
    logic                writeHit;
    logic [31:0]         dedSyncWord;
    logic [31:0]         dedLatchWord;
    logic [31:0]         pinSyncWord;
    logic [31:0]         pinLatchWord;
    logic [31:0]         clkSelWord;
    logic [31:0]         syncSelWord;
    logic [31:0]         enPolWord;
    logic [31:0]         outInvWord;

    function automatic pam_in_mode_e inMode(input logic syncSel, input logic latchSel);
        if (!syncSel) begin
            return IN_ASYNC;
        end else if (latchSel) begin
            return IN_LATCH;
        end
        return IN_REG;
    endfunction

    function automatic pam_cell_mode_e cellMode(input logic syncSel, input logic clkSrcSel);
        if (!syncSel) begin
            return CELL_COMB;
        end else if (clkSrcSel) begin
            return CELL_TERM_CLK;
        end
        return CELL_EN_REG;
    endfunction

    // one group of input cells; both groups share this decode
    function automatic logic [NUM_IN-1:0] inCells(input logic [NUM_IN-1:0] pins, input logic [NUM_IN-1:0] held,
                                                  input pam_in_cfg_s cfg, input logic clkLvl, input logic clkRise);
        logic [NUM_IN-1:0] res;
        res = held;
        for (int i = 0; i < NUM_IN; i++) begin
            case (inMode(cfg.syncSel[i], cfg.latchSel[i]))
                IN_ASYNC: res[i] = pins[i];
                IN_LATCH: res[i] = clkLvl ? pins[i] : held[i];
                IN_REG:   res[i] = clkRise ? pins[i] : held[i];
                default:  res[i] = held[i];
            endcase
        end
        return res;
    endfunction

    function automatic logic [31:0] strobed(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // pin and clock synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dedMeta   <= '0;
            dedSync   <= '0;
            pinMeta   <= '0;
            pinSync   <= '0;
            inClkMeta <= '0;
            inClkSync <= '0;
        end else begin
            dedMeta   <= dedicatedInPin;
            dedSync   <= dedMeta;
            pinMeta   <= bidirPinIn;
            pinSync   <= pinMeta;
            inClkMeta <= {stateRegisterClock, inputSideClock};
            inClkSync <= inClkMeta;
        end
    end

    assign inClkRise = inClkSync[0] && !inClkPrev;
    assign stClkRise = inClkSync[1] && !stClkPrev;
    assign cellEn    = enableSumTerm ^ cellCfg.enPol;

    // input cells
    always_comb begin
        next_dedIn = inCells(dedSync, dedicatedInToArray, dedCfg, inClkSync[0], inClkRise);
        next_pinIn = inCells(pinSync, pinInToArray, pinCfg, inClkSync[0], inClkRise);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            inClkPrev          <= 1'b0;
            dedicatedInToArray <= '0;
            pinInToArray       <= '0;
        end else begin
            inClkPrev          <= inClkSync[0];
            dedicatedInToArray <= next_dedIn;
            pinInToArray       <= next_pinIn;
        end
    end

    // state cells, pin-driving first then hidden
    always_comb begin
        next_cell = cellFeedback;
        for (int i = 0; i < NUM_CELL; i++) begin
            case (cellMode(cellCfg.syncSel[i], cellCfg.clkSrcSel[i]))
                CELL_COMB: next_cell[i] = dataSumTerm[i];
                CELL_TERM_CLK: begin
                    if (cellEn[i] && !enPrev[i]) begin
                        next_cell[i] = dataSumTerm[i];
                    end
                end
                CELL_EN_REG: begin
                    if (stClkRise && cellEn[i]) begin
                        next_cell[i] = dataSumTerm[i];
                    end
                end
                default: next_cell[i] = cellFeedback[i];
            endcase
        end
        if (resetTerm) begin
            next_cell = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stClkPrev     <= 1'b0;
            enPrev        <= '0;
            cellFeedback  <= '0;
            cellFeedbackN <= '1;
            bidirPinOut   <= '1;
            bidirPinOe_n  <= '1;
        end else begin
            stClkPrev     <= inClkSync[1];
            enPrev        <= cellEn;
            cellFeedback  <= next_cell;
            cellFeedbackN <= ~next_cell;
            bidirPinOut   <= ~next_cell[NUM_PIN-1:0] ^ outInv;
            bidirPinOe_n  <= ~outputEnableTerm;
        end
    end

    // register bus, write side
    assign writeCommit = gotAw && gotW && !s_axil_bvalid;
    assign writeHit    = awAddr inside {ADDR_DED_CFG, ADDR_PIN_CFG, ADDR_CLK_SEL, ADDR_SYNC_SEL,
                                        ADDR_EN_POL, ADDR_OUT_INV};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axil_awready <= 1'b1;
            s_axil_wready  <= 1'b1;
            s_axil_bvalid  <= 1'b0;
            s_axil_bresp   <= RESP_OKAY;
            gotAw          <= 1'b0;
            gotW           <= 1'b0;
            awAddr         <= '0;
            wData          <= '0;
            wStrb          <= '0;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                s_axil_awready <= 1'b0;
                gotAw          <= 1'b1;
                awAddr         <= {s_axil_awaddr[4:2], 2'h0};
            end
            if (s_axil_wvalid && s_axil_wready) begin
                s_axil_wready <= 1'b0;
                gotW          <= 1'b1;
                wData         <= s_axil_wdata;
                wStrb         <= s_axil_wstrb;
            end
            if (writeCommit) begin
                gotAw         <= 1'b0;
                gotW          <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid  <= 1'b0;
                s_axil_awready <= 1'b1;
                s_axil_wready  <= 1'b1;
            end
        end
    end

    // merged register words, strobes applied over the current bits
    assign dedSyncWord  = strobed({22'h0, dedCfg.syncSel}, wData, wStrb);
    assign dedLatchWord = strobed({6'h0, dedCfg.latchSel, 16'h0}, wData, wStrb);
    assign pinSyncWord  = strobed({22'h0, pinCfg.syncSel}, wData, wStrb);
    assign pinLatchWord = strobed({6'h0, pinCfg.latchSel, 16'h0}, wData, wStrb);
    assign clkSelWord   = strobed({14'h0, cellCfg.clkSrcSel}, wData, wStrb);
    assign syncSelWord  = strobed({14'h0, cellCfg.syncSel}, wData, wStrb);
    assign enPolWord    = strobed({14'h0, cellCfg.enPol}, wData, wStrb);
    assign outInvWord   = strobed({22'h0, outInv}, wData, wStrb);

    // configuration bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dedCfg  <= '{syncSel: IN_CFG_RST, latchSel: IN_CFG_RST};
            pinCfg  <= '{syncSel: IN_CFG_RST, latchSel: IN_CFG_RST};
            cellCfg <= '{clkSrcSel: CELL_CFG_RST, syncSel: CELL_CFG_RST, enPol: CELL_CFG_RST};
            outInv  <= OUT_INV_RST;
        end else if (writeCommit) begin
            case (awAddr)
                ADDR_DED_CFG: begin
                    dedCfg.syncSel  <= dedSyncWord[NUM_IN-1:0];
                    dedCfg.latchSel <= dedLatchWord[IN_LATCH_LSB +: NUM_IN];
                end
                ADDR_PIN_CFG: begin
                    pinCfg.syncSel  <= pinSyncWord[NUM_IN-1:0];
                    pinCfg.latchSel <= pinLatchWord[IN_LATCH_LSB +: NUM_IN];
                end
                ADDR_CLK_SEL:  cellCfg.clkSrcSel <= clkSelWord[NUM_CELL-1:0];
                ADDR_SYNC_SEL: cellCfg.syncSel   <= syncSelWord[NUM_CELL-1:0];
                ADDR_EN_POL:   cellCfg.enPol     <= enPolWord[NUM_CELL-1:0];
                ADDR_OUT_INV:  outInv            <= outInvWord[NUM_PIN-1:0];
                default: ;
            endcase
        end
    end

    // register bus, read side
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axil_arready <= 1'b1;
            s_axil_rvalid  <= 1'b0;
            s_axil_rdata   <= '0;
            s_axil_rresp   <= RESP_OKAY;
        end else begin
            if (s_axil_arvalid && s_axil_arready) begin
                s_axil_arready <= 1'b0;
                s_axil_rvalid  <= 1'b1;
                s_axil_rresp   <= RESP_OKAY;
                case ({s_axil_araddr[4:2], 2'h0})
                    ADDR_DED_CFG:   s_axil_rdata <= {6'h0, dedCfg.latchSel, 6'h0, dedCfg.syncSel};
                    ADDR_PIN_CFG:   s_axil_rdata <= {6'h0, pinCfg.latchSel, 6'h0, pinCfg.syncSel};
                    ADDR_CLK_SEL:   s_axil_rdata <= {14'h0, cellCfg.clkSrcSel};
                    ADDR_SYNC_SEL:  s_axil_rdata <= {14'h0, cellCfg.syncSel};
                    ADDR_EN_POL:    s_axil_rdata <= {14'h0, cellCfg.enPol};
                    ADDR_OUT_INV:   s_axil_rdata <= {22'h0, outInv};
                    ADDR_CELL_STAT: s_axil_rdata <= {14'h0, cellFeedback};
                    ADDR_IN_STAT:   s_axil_rdata <= {6'h0, pinInToArray, 6'h0, dedicatedInToArray};
                    default: begin
                        s_axil_rdata <= '0;
                        s_axil_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axil_rvalid && s_axil_rready) begin
                s_axil_rvalid  <= 1'b0;
                s_axil_arready <= 1'b1;
            end
        end
    end
endmodule

/* verif/pam_top_monitor.sv */
`timescale 1ns/1ns
module pam_top_monitor
    import pam_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                s_axil_awvalid,
    input wire logic                s_axil_awready,
    input wire logic                s_axil_wvalid,
    input wire logic                s_axil_wready,
    input wire logic                s_axil_bvalid,
    input wire logic                s_axil_arvalid,
    input wire logic                s_axil_arready,
    input wire logic                s_axil_rvalid,
    input wire logic [NUM_PIN-1:0]  outputEnableTerm,
    input wire logic                resetTerm,
    input wire logic [NUM_CELL-1:0] cellFeedback,
    input wire logic [NUM_CELL-1:0] cellFeedbackN,
    input wire logic [NUM_PIN-1:0]  bidirPinOe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RST_TERM_CLEAR: assert property (resetTerm |=> cellFeedback == '0)
        else $error("cells not cleared");
    AST_RST_TERM_HOLD: assert property (resetTerm [*2] |=> cellFeedbackN == '1)
        else $error("complement not all one");
    AST_TRUE_COMPL: assert property (cellFeedbackN == ~cellFeedback)
        else $error("feedback pair mismatch");
    AST_OE_TERM: assert property ($past(rst_n) |-> bidirPinOe_n == ~$past(outputEnableTerm))
        else $error("pin direction wrong");
    AST_WRITE_RESP: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##2 s_axil_bvalid)
        else $error("write answer late");
    AST_READ_RESP: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read answer late");
    AST_AW_REFUSED: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
        else $error("write not refused");
    AST_AR_REFUSED: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read not refused");
    COV_RST_TERM: cover property (resetTerm ##1 !resetTerm);
    COV_WRITE: cover property (s_axil_bvalid);
    COV_READ: cover property (s_axil_rvalid);
endmodule

bind pam_top pam_top_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rvalid(s_axil_rvalid), .outputEnableTerm(outputEnableTerm), .resetTerm(resetTerm),
    .cellFeedback(cellFeedback), .cellFeedbackN(cellFeedbackN), .bidirPinOe_n(bidirPinOe_n));

/* verif/pam_board_model.sv */
`timescale 1ns/1ns
module pam_board_model
    import pam_pkg::*;
(
    input wire logic [NUM_PIN-1:0] bidirPinOut,
    input wire logic [NUM_PIN-1:0] bidirPinOe_n,
    input wire logic [NUM_PIN-1:0] boardDrive,
    input wire logic [NUM_PIN-1:0] boardDriveEn,
    output logic     [NUM_PIN-1:0] pinLevel
);
    // device drive wins, then board drive, else the pull-up
    assign pinLevel = (~bidirPinOe_n & bidirPinOut) | (bidirPinOe_n & boardDriveEn & boardDrive)
                    | (bidirPinOe_n & ~boardDriveEn);
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    import pam_pkg::*;
    typedef struct {logic [4:0] a; logic [31:0] w; logic [1:0] resp; logic [31:0] rb;} pam_row_s;
    logic                clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic                input_side_clock = 1'b0, sclk = 1'b0, rstT = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]          bresp, rresp;
    logic [4:0]          awaddr = '0, araddr = '0;
    logic [31:0]         wdata = '0, rdata, rdV;
    logic [NUM_IN-1:0]   dedIn = '0, dedArr;
    logic [NUM_PIN-1:0]  brdDrv = '0, brdEn = '0, oeT = '0, pinOut, oeN, pinLvl, pinArr;
    logic [NUM_CELL-1:0] dataT = '0, enT = '0, fb, fbN;
    int                  n_mismatch = 0, total_checks = 0, cycles = 0;
    pam_row_s            rows [8] = '{'{ADDR_DED_CFG, 32'hffffffff, RESP_OKAY, 32'h03ff03ff},
        '{ADDR_PIN_CFG, 32'h12345678, RESP_OKAY, 32'h02340278}, '{ADDR_CLK_SEL, 32'hffffffff, RESP_OKAY, 32'h3ffff},
        '{ADDR_SYNC_SEL, 32'hffffffff, RESP_OKAY, 32'h3ffff}, '{ADDR_EN_POL, 32'h000a5a5a, RESP_OKAY, 32'h25a5a},
        '{ADDR_OUT_INV, 32'hffffffff, RESP_OKAY, 32'h3ff}, '{ADDR_CELL_STAT, 32'h1, RESP_SLVERR, 32'h0},
        '{ADDR_IN_STAT, 32'h1, RESP_SLVERR, 32'h0}};
    always #5 clk = ~clk;
    pam_top DUT (.sys_clk(clk), .rst_n(rst_n), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(1'b1),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(1'b1), .inputSideClock(input_side_clock),
        .stateRegisterClock(sclk), .dedicatedInPin(dedIn), .bidirPinIn(pinLvl), .dataSumTerm(dataT),
        .enableSumTerm(enT), .outputEnableTerm(oeT), .resetTerm(rstT), .dedicatedInToArray(dedArr),
        .pinInToArray(pinArr), .cellFeedback(fb), .cellFeedbackN(fbN), .bidirPinOut(pinOut), .bidirPinOe_n(oeN));
    pam_board_model u_board (.bidirPinOut(pinOut), .bidirPinOe_n(oeN), .boardDrive(brdDrv), .boardDriveEn(brdEn),
        .pinLevel(pinLvl));
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        `CHK(rresp, RESP_OKAY)
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(fb, 18'h0)
        `CHK(pinOut, 10'h3ff)
        `CHK(oeN, 10'h3ff)
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w, rows[i].resp);
            if (rows[i].resp === RESP_OKAY) begin
                rd(rows[i].a, rdV);
                `CHK(rdV, rows[i].rb)
            end
        end
        for (int i = 0; i < 6; i++) wr(5'(i * 4), 32'h0, RESP_OKAY);
        dataT <= 18'h2a5a5;
        dedIn <= 10'h155;
        oeT <= 10'h00f;
        brdEn <= 10'h0f0;
        brdDrv <= 10'h0a0;
        settle();
        `CHK(fb, 18'h2a5a5)
        `CHK(fbN, 18'h15a5a)
        `CHK(pinOut, 10'h25a)
        `CHK(oeN, 10'h3f0)
        rd(ADDR_IN_STAT, rdV);
        `CHK(rdV, 32'h03aa0155)
        rd(ADDR_CELL_STAT, rdV);
        `CHK(rdV, 32'h0002a5a5)
        wr(ADDR_OUT_INV, 32'h3ff, RESP_OKAY);
        settle();
        `CHK(pinOut, 10'h1a5)
        wr(ADDR_OUT_INV, 32'h0, RESP_OKAY);
        wr(ADDR_DED_CFG, 32'h3ff, RESP_OKAY);
        dedIn <= 10'h2aa;
        brdDrv <= 10'h050;
        input_side_clock <= 1'b1;
        settle();
        `CHK(dedArr, 10'h2aa)
        `CHK(pinArr, 10'h35a)
        dedIn <= 10'h0cc;
        settle();
        `CHK(dedArr, 10'h2aa)
        wr(ADDR_DED_CFG, 32'h03ff03ff, RESP_OKAY);
        settle();
        `CHK(dedArr, 10'h0cc)
        input_side_clock <= 1'b0;
        settle();
        dedIn <= 10'h033;
        settle();
        `CHK(dedArr, 10'h0cc)
        wr(ADDR_SYNC_SEL, 32'h3ffff, RESP_OKAY);
        rstT <= 1'b1;
        repeat (2) @(posedge clk);
        rstT <= 1'b0;
        settle();
        `CHK(fb, 18'h0)
        `CHK(pinOut, 10'h3ff)
        dataT <= 18'h3ffff;
        enT <= 18'h0000f;
        settle();
        `CHK(fb, 18'h0)
        sclk <= 1'b1;
        settle();
        `CHK(fb, 18'h0000f)
        sclk <= 1'b0;
        wr(ADDR_EN_POL, 32'h3ffff, RESP_OKAY);
        sclk <= 1'b1;
        settle();
        `CHK(fb, 18'h3ffff)
        sclk <= 1'b0;
        wr(ADDR_CLK_SEL, 32'h3ffff, RESP_OKAY);
        wr(ADDR_EN_POL, 32'h0, RESP_OKAY);
        dataT <= 18'h0;
        enT <= 18'h0;
        settle();
        `CHK(fb, 18'h3ffff)
        enT <= 18'h00ff0;
        settle();
        `CHK(fb, 18'h3f00f)
        results();
    end
endmodule
